// [rtl/edge_irq_pkg.sv]
/*
 Constants for the edge interrupt flag block: register word offsets,
 field positions and reset values.
 Assumes a 32-bit Avalon-MM slave with byte addressing.
*/
package edge_irq_pkg;
    localparam int PIN_COUNT = 8;
    localparam int ADDR_WIDTH = 5;
    // Byte offsets of the register words
    localparam logic [4:0] OFS_PIN_FLAGS = 5'h00;
    localparam logic [4:0] OFS_PIN_ENABLE = 5'h04;
    localparam logic [4:0] OFS_TIMER_CTRL = 5'h08;
    localparam logic [4:0] OFS_EVT_STATUS = 5'h0C;
    localparam logic [4:0] OFS_EVT_ENABLE = 5'h10;
    localparam logic [4:0] OFS_EVT_CLEAR = 5'h14;
    localparam logic [4:0] OFS_TIMER_COUNT = 5'h18;
    // Field positions in timer control word
    localparam int TMR_FLAG_BIT = 0;
    localparam int TMR_ENABLE_BIT = 1;
    // Event status layout: bits 7..0 pin flags set, bit 8 timer overflow
    localparam int EVT_WIDTH = 9;
    localparam int EVT_TIMER_BIT = 8;
    // Reset values and the timer count maximum
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// [rtl/edge_irq_flag_logic.sv]
/*
 Edge interrupt request flags for eight pins plus the 8-bit timer B1
 overflow flag, with enables, a sticky event status and one interrupt line.
 Assumes pins are asynchronous, the timer count increments from this
 block's clock via a count strobe, and the bus is Avalon-MM with waitrequest.
*/
`timescale 1ns/1ps

// Summary of operation
// [RULE_01] Enabled pin flag raises CPU request
// [RULE_02] Disabled pin gives no request; enables reset 0
// [RULE_03] Timer overflow FF to 00 sets flag
// [RULE_04] Writing 0 clears set timer flag
// [RULE_05] Selected pin edge sets pin flag
// [RULE_06] Writing 0 clears set pin flag
// [RULE_07] Writing 1 never sets any flag
// [RULE_08] Eight pin flags, bit n pin n, reset 0
// [RULE_09] Request when flag and enable both 1
module edge_irq_flag_logic
    import edge_irq_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // External pins and edge selection (1 = rising, 0 = falling)
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] pin_edge_rising,
    // Timer B1 count strobe
    input wire logic timer_b1_tick,
    // Avalon-MM slave
    input wire logic [edge_irq_pkg::ADDR_WIDTH-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // CPU requests
    output logic [PINS-1:0] pin_irq_request,
    output logic timer_b1_irq_request,
    output logic irq
);
    import edge_irq_pkg::*;

    logic [PINS-1:0] pin_meta;
    logic [PINS-1:0] pin_sync;
    logic [PINS-1:0] pin_prev;
    logic [PINS-1:0] edge_seen;
    logic [2:0] arm_pipe;
    logic [PINS-1:0] pin_irq_request_flags;
    logic [PINS-1:0] pin_irq_enable_bits;
    logic timer_b1_overflow_request;
    logic timer_b1_enable;
    logic [7:0] timer_b1_count;
    logic timer_b1_wrap;
    logic [EVT_WIDTH-1:0] evt_status;
    logic [EVT_WIDTH-1:0] evt_enable;
    logic [EVT_WIDTH-1:0] evt_set;
    logic served;
    logic access;
    logic wr_go;
    logic lane0;
    logic lane1;
    logic count_wr;
    logic [31:0] next_readdata;

    // One wait cycle per access, then the answer
    assign access = read | write;
    assign waitrequest = access & ~served;
    assign wr_go = write & served;
    assign lane0 = byteenable[0];
    assign lane1 = byteenable[1];
    assign count_wr = wr_go && address == OFS_TIMER_COUNT && lane0;

    always_ff @(posedge clock) begin
        if (reset) begin
            served <= 1'b0;
        end else begin
            served <= access & ~served;
        end
    end

    // Two-stage synchroniser, edge detect on the second stage only
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Edges ignored until the history flop holds a real pin level,
    // so a pin idling high cannot fake an edge after reset
    always_ff @(posedge clock) begin
        if (reset) begin
            arm_pipe <= 3'h0;
        end else begin
            arm_pipe <= {arm_pipe[1:0], 1'b1};
        end
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            assign edge_seen[g] = arm_pipe[2]
                                & (pin_edge_rising[g] ? (pin_sync[g] & ~pin_prev[g])
                                                      : (~pin_sync[g] & pin_prev[g]));
            always_ff @(posedge clock) begin
                if (reset) begin
                    pin_irq_request_flags[g] <= FLAGS_RESET[g]; // RULE_08
                end else if (edge_seen[g]) begin
                    // Set beats a simultaneous clear
                    pin_irq_request_flags[g] <= 1'b1; // RULE_05
                end else if (wr_go && address == OFS_PIN_FLAGS && lane0
                             && !writedata[g] && pin_irq_request_flags[g]) begin
                    pin_irq_request_flags[g] <= 1'b0; // RULE_06 RULE_07
                end
            end
            assign pin_irq_request[g] = pin_irq_request_flags[g]
                                      & pin_irq_enable_bits[g]; // RULE_01 RULE_02 RULE_09
            a_pin_edge_set: assert property (@(posedge clock) disable iff (reset) // RULE_05
                (arm_pipe[2] && pin_sync[g] != pin_prev[g]
                 && pin_sync[g] == pin_edge_rising[g]) |=> pin_irq_request_flags[g])
                else $error("selected edge did not set its flag");
            a_pin_other_edge: assert property (@(posedge clock) disable iff (reset) // RULE_05
                (pin_sync[g] != pin_prev[g] && pin_sync[g] != pin_edge_rising[g]
                 && !pin_irq_request_flags[g]) |=> !pin_irq_request_flags[g])
                else $error("other edge set a flag");
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (reset) begin
            pin_irq_enable_bits <= ENABLE_RESET; // RULE_02
        end else if (wr_go && address == OFS_PIN_ENABLE && lane0) begin
            pin_irq_enable_bits <= writedata[PINS-1:0];
        end
    end

    // Timer B1 counter; overflow when it rolls from maximum to zero
    // A software load beats the tick in the same cycle, so no rollover then
    assign timer_b1_wrap = timer_b1_tick && !count_wr && timer_b1_count == COUNT_MAX;

    always_ff @(posedge clock) begin
        if (reset) begin
            timer_b1_count <= COUNT_ZERO;
        end else if (count_wr) begin
            timer_b1_count <= writedata[7:0];
        end else if (timer_b1_tick) begin
            timer_b1_count <= timer_b1_count + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            timer_b1_overflow_request <= 1'b0;
        end else if (timer_b1_wrap) begin
            timer_b1_overflow_request <= 1'b1; // RULE_03
        end else if (wr_go && address == OFS_TIMER_CTRL && lane0
                     && !writedata[TMR_FLAG_BIT] && timer_b1_overflow_request) begin
            timer_b1_overflow_request <= 1'b0; // RULE_04 RULE_07
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            timer_b1_enable <= 1'b0;
        end else if (wr_go && address == OFS_TIMER_CTRL && lane0) begin
            timer_b1_enable <= writedata[TMR_ENABLE_BIT];
        end
    end

    assign timer_b1_irq_request = timer_b1_overflow_request & timer_b1_enable; // RULE_09

    // Sticky event log for the interrupt line
    assign evt_set = {timer_b1_wrap, edge_seen};

    always_ff @(posedge clock) begin
        if (reset) begin
            evt_status <= '0;
        end else if (wr_go && address == OFS_EVT_CLEAR) begin
            evt_status <= evt_set | (evt_status & ~{writedata[8] & lane1,
                                                   writedata[7:0] & {8{lane0}}});
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            evt_enable <= '0;
        end else if (wr_go && address == OFS_EVT_ENABLE) begin
            if (lane0) begin
                evt_enable[7:0] <= writedata[7:0];
            end
            if (lane1) begin
                evt_enable[EVT_TIMER_BIT] <= writedata[8];
            end
        end
    end

    assign irq = |(evt_status & evt_enable);

    always_comb begin
        next_readdata = UNMAPPED_READ;
        case (address)
            OFS_PIN_FLAGS: next_readdata[PINS-1:0] = pin_irq_request_flags;
            OFS_PIN_ENABLE: next_readdata[PINS-1:0] = pin_irq_enable_bits;
            OFS_TIMER_CTRL: begin
                next_readdata[TMR_FLAG_BIT] = timer_b1_overflow_request;
                next_readdata[TMR_ENABLE_BIT] = timer_b1_enable;
            end
            OFS_EVT_STATUS: next_readdata[EVT_WIDTH-1:0] = evt_status;
            OFS_EVT_ENABLE: next_readdata[EVT_WIDTH-1:0] = evt_enable;
            OFS_TIMER_COUNT: next_readdata[7:0] = timer_b1_count;
            default: next_readdata = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            readdata <= UNMAPPED_READ;
        end else if (read && !served) begin
            readdata <= next_readdata;
        end
    end

    a_pin_request_gate: assert property (@(posedge clock) disable iff (reset) // RULE_09
        pin_irq_request == (pin_irq_request_flags & pin_irq_enable_bits))
        else $error("pin request not flag and enable");
    a_edge_sets_flag: assert property (@(posedge clock) disable iff (reset) // RULE_05
        |edge_seen |=> (pin_irq_request_flags & $past(edge_seen)) == $past(edge_seen))
        else $error("edge did not set flag");
    a_write_one_holds: assert property (@(posedge clock) disable iff (reset) // RULE_07
        (wr_go && address == OFS_PIN_FLAGS && writedata[7:0] == 8'hFF)
        |=> pin_irq_request_flags == ($past(pin_irq_request_flags) | $past(edge_seen)))
        else $error("write of ones changed flags");
    a_pin_clear: assert property (@(posedge clock) disable iff (reset) // RULE_06
        (wr_go && address == OFS_PIN_FLAGS && lane0 && writedata[7:0] == 8'h00
         && edge_seen == '0) |=> pin_irq_request_flags == 8'h00)
        else $error("pin flags not cleared");
    a_timer_set: assert property (@(posedge clock) disable iff (reset) // RULE_03
        timer_b1_wrap |=> timer_b1_overflow_request && timer_b1_count == COUNT_ZERO)
        else $error("overflow flag not set");
    a_timer_clear: assert property (@(posedge clock) disable iff (reset) // RULE_04
        (wr_go && address == OFS_TIMER_CTRL && lane0 && !writedata[TMR_FLAG_BIT]
         && !timer_b1_wrap) |=> !timer_b1_overflow_request)
        else $error("overflow flag not cleared");
    a_disabled_quiet: assert property (@(posedge clock) disable iff (reset) // RULE_02
        |(~pin_irq_enable_bits) |-> (pin_irq_request & ~pin_irq_enable_bits) == '0)
        else $error("disabled pin requests");
    a_enabled_raise: assert property (@(posedge clock) disable iff (reset) // RULE_01
        (pin_irq_enable_bits[0] && pin_irq_request_flags[0]) |-> pin_irq_request[0])
        else $error("enabled flag gave no request");
    a_bus_answer: assert property (@(posedge clock) disable iff (reset) // RULE_08
        (read && !served && address == OFS_PIN_FLAGS)
        |=> !waitrequest && readdata[7:0] == $past(pin_irq_request_flags))
        else $error("flag read wrong");

    // Reset state of the flag and enable words
    a_flags_reset: assert property (@(posedge clock) disable iff (reset) // RULE_08
        $fell(reset) |-> pin_irq_request_flags == FLAGS_RESET)
        else $error("pin flags not zero after reset");
    a_enables_reset: assert property (@(posedge clock) disable iff (reset) // RULE_02
        $fell(reset) |-> pin_irq_enable_bits == ENABLE_RESET)
        else $error("enables not zero after reset");

    // Pin flags move only by edge or by a write of 0
    a_flag_needs_edge: assert property (@(posedge clock) disable iff (reset) // RULE_07
        1'b1 |=> (pin_irq_request_flags & ~$past(pin_irq_request_flags)
                  & ~$past(edge_seen)) == '0)
        else $error("pin flag rose without an edge");
    a_flag_holds: assert property (@(posedge clock) disable iff (reset) // RULE_06
        !(wr_go && address == OFS_PIN_FLAGS && lane0)
        |=> (pin_irq_request_flags & $past(pin_irq_request_flags))
            == $past(pin_irq_request_flags))
        else $error("pin flag fell without a write");
    a_clear_bitwise: assert property (@(posedge clock) disable iff (reset) // RULE_06
        (wr_go && address == OFS_PIN_FLAGS && lane0)
        |=> pin_irq_request_flags == (($past(pin_irq_request_flags) & $past(writedata[PINS-1:0]))
                                      | $past(edge_seen)))
        else $error("pin flag write result wrong");

    // Enable word
    a_enable_write: assert property (@(posedge clock) disable iff (reset) // RULE_01
        (wr_go && address == OFS_PIN_ENABLE && lane0)
        |=> pin_irq_enable_bits == $past(writedata[PINS-1:0]))
        else $error("enable write lost");
    a_enable_hold: assert property (@(posedge clock) disable iff (reset) // RULE_02
        !(wr_go && address == OFS_PIN_ENABLE && lane0) |=> $stable(pin_irq_enable_bits))
        else $error("enable changed without a write");
    a_enable_read: assert property (@(posedge clock) disable iff (reset) // RULE_02
        (read && !served && address == OFS_PIN_ENABLE)
        |=> readdata[PINS-1:0] == $past(pin_irq_enable_bits))
        else $error("enable read wrong");

    // Timer B1 flag and count
    a_timer_gate: assert property (@(posedge clock) disable iff (reset) // RULE_09
        timer_b1_irq_request == (timer_b1_overflow_request && timer_b1_enable))
        else $error("timer request not flag and enable");
    a_timer_only_wrap: assert property (@(posedge clock) disable iff (reset) // RULE_07
        !timer_b1_wrap |=> !$rose(timer_b1_overflow_request))
        else $error("overflow flag rose without overflow");
    a_timer_holds: assert property (@(posedge clock) disable iff (reset) // RULE_04
        (timer_b1_overflow_request
         && !(wr_go && address == OFS_TIMER_CTRL && lane0 && !writedata[TMR_FLAG_BIT]))
        |=> timer_b1_overflow_request)
        else $error("overflow flag fell without a clear");
    a_timer_read: assert property (@(posedge clock) disable iff (reset) // RULE_04
        (read && !served && address == OFS_TIMER_CTRL)
        |=> readdata[TMR_FLAG_BIT] == $past(timer_b1_overflow_request))
        else $error("overflow flag read wrong");
    a_count_step: assert property (@(posedge clock) disable iff (reset) // RULE_03
        (timer_b1_tick && !count_wr)
        |=> timer_b1_count == $past(timer_b1_count) + 8'h01)
        else $error("timer count did not step");

    // Event log, interrupt line and bus timing
    a_evt_capture: assert property (@(posedge clock) disable iff (reset) // RULE_05
        1'b1 |=> (evt_status & $past(evt_set)) == $past(evt_set))
        else $error("event not logged");
    a_evt_sticky: assert property (@(posedge clock) disable iff (reset) // RULE_09
        !(wr_go && address == OFS_EVT_CLEAR)
        |=> (evt_status & $past(evt_status)) == $past(evt_status))
        else $error("event bit fell without a clear");
    a_evt_clear: assert property (@(posedge clock) disable iff (reset) // RULE_09
        (wr_go && address == OFS_EVT_CLEAR && lane0 && lane1
         && &writedata[EVT_WIDTH-1:0] && evt_set == '0) |=> evt_status == '0)
        else $error("event clear failed");
    a_evt_enable_write: assert property (@(posedge clock) disable iff (reset) // RULE_09
        (wr_go && address == OFS_EVT_ENABLE && lane0 && lane1)
        |=> evt_enable == $past(writedata[EVT_WIDTH-1:0]))
        else $error("event enable write lost");
    a_irq_level: assert property (@(posedge clock) disable iff (reset) // RULE_09
        irq == |(evt_status & evt_enable))
        else $error("interrupt line wrong");
    a_one_wait: assert property (@(posedge clock) disable iff (reset) // RULE_08
        (access && waitrequest) |=> !waitrequest)
        else $error("more than one wait cycle");
    a_readdata_stands: assert property (@(posedge clock) disable iff (reset) // RULE_08
        !(read && !served) |=> $stable(readdata))
        else $error("read data moved between reads");
endmodule

// [bench/edge_pin_model.sv]
/*
 Far-side model of the eight external interrupt pins.
 Assumes the bench asks for pin levels on target; pins follow one edge later.
*/
`timescale 1ns/1ps
module edge_pin_model (
    // Clock and requested levels
    input wire logic clock,
    input wire logic [7:0] target,
    // Pin levels
    output logic [7:0] pin_in
);
    // Pins change only after an edge, never in the sampling step
    always @(posedge clock) begin
        pin_in <= target;
    end
endmodule

// [bench/edge_irq_flag_logic_tb_top.sv]
/*
 Bench for the edge flag block: random pin edges, flag clearing, enables,
 timer overflow and the event interrupt.
 Assumes the package offsets; bus requests wait for waitrequest low.
*/
`timescale 1ns/1ps
module edge_irq_flag_logic_tb_top;
    import edge_irq_pkg::*;
    logic clock = 0, reset = 1, read = 0, write = 0, timer_b1_tick = 0;
    logic [7:0] target = 0, sel = 0, pin_in, pin_irq_request, m, en, w, ev = 0;
    logic [4:0] address = 0;
    logic [3:0] be = 4'hf;
    logic [31:0] writedata = 0, readdata, q, rnd = 32'h44f8_f7db;
    logic waitrequest, timer_b1_irq_request, irq;
    int fails = 0, comparisons = 0;
    always #2 clock = ~clock;
    edge_pin_model edge_pin_model_i (.clock(clock), .target(target), .pin_in(pin_in));
    edge_irq_flag_logic edge_irq_flag_logic_i (.clock(clock), .reset(reset), .pin_in(pin_in),
        .pin_edge_rising(sel), .timer_b1_tick(timer_b1_tick), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(be),
        .readdata(readdata), .waitrequest(waitrequest), .pin_irq_request(pin_irq_request),
        .timer_b1_irq_request(timer_b1_irq_request), .irq(irq));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_line(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        write <= wr;
        read <= !wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0;
        write <= 0;
    endtask
    task automatic tick;
        @(posedge clock);
        timer_b1_tick <= 1;
        @(posedge clock);
        timer_b1_tick <= 0;
    endtask
    task report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        report_and_stop;
    end
    initial begin
        repeat (20) @(posedge clock);
        reset <= 0;
        bus(0, OFS_PIN_FLAGS, 0);
        chk(q, 0);
        bus(0, OFS_PIN_ENABLE, 0);
        chk(q, 0);
        $display("test reset done");
        for (int k = 0; k < 5; k++) begin
            rnd = lfsr(rnd);
            m = (k == 0) ? 8'hff : rnd[15:8];
            @(posedge clock);
            sel <= rnd[7:0];
            target <= ~rnd[7:0];
            repeat (8) @(posedge clock);
            bus(1, OFS_PIN_FLAGS, 0);
            bus(1, OFS_PIN_ENABLE, 0);
            // Only pins in m move to the selected level
            target <= ~sel ^ m;
            repeat (8) @(posedge clock);
            ev = ev | m;
            @(negedge clock);
            chk_line(pin_irq_request, 8'h00);
            bus(0, OFS_PIN_FLAGS, 0);
            chk(q, {24'h0, m});
            rnd = lfsr(rnd);
            en = rnd[7:0];
            w = (k == 0) ? 8'h00 : rnd[15:8];
            bus(1, OFS_PIN_ENABLE, {24'h0, en});
            @(negedge clock);
            chk_line(pin_irq_request, m & en);
            bus(1, OFS_PIN_FLAGS, 32'h0000_00ff);
            bus(0, OFS_PIN_FLAGS, 0);
            chk(q, {24'h0, m});
            bus(1, OFS_PIN_FLAGS, {24'h0, w});
            bus(0, OFS_PIN_FLAGS, 0);
            chk(q, {24'h0, m & w});
        end
        $display("test pins done");
        bus(0, OFS_EVT_STATUS, 0);
        chk(q, {24'h0, ev});
        bus(1, OFS_EVT_ENABLE, 32'h0000_01ff);
        @(negedge clock);
        chk_line({7'h0, irq}, 8'h01);
        bus(1, OFS_EVT_CLEAR, 32'h0000_01ff);
        @(negedge clock);
        chk_line({7'h0, irq}, 8'h00);
        bus(1, OFS_TIMER_COUNT, 32'h0000_00fe);
        tick;
        bus(0, OFS_TIMER_CTRL, 0);
        chk(q, 0);
        tick;
        bus(0, OFS_TIMER_CTRL, 0);
        chk(q, 1);
        // A clearing write with no byte lane enabled must leave the flag
        be <= 4'h0;
        bus(1, OFS_TIMER_CTRL, 0);
        be <= 4'hf;
        bus(0, OFS_TIMER_CTRL, 0);
        chk(q, 1);
        bus(0, OFS_TIMER_COUNT, 0);
        chk(q, {24'h0, COUNT_ZERO});
        @(negedge clock);
        chk_line({7'h0, irq}, 8'h01);
        bus(1, OFS_TIMER_CTRL, 32'h0000_0003);
        @(negedge clock);
        chk_line({7'h0, timer_b1_irq_request}, 8'h01);
        bus(1, OFS_TIMER_CTRL, 32'h0000_0002);
        @(negedge clock);
        chk_line({7'h0, timer_b1_irq_request}, 8'h00);
        bus(0, 5'h1c, 0);
        chk(q, UNMAPPED_READ);
        $display("test timer and events done");
        report_and_stop;
    end
endmodule
